// *** core/tcw_timer.sv ***
// Timer compare and waveform unit: counter, two compare channels, APB registers
// How it works
// [R1] Counter write blocks matches for next tick
// [R2] Mode switch keeps output state unchanged
// [R3] Nonzero action overrides port; direction bit gates
// [R4] Action zero never changes output state
// [R5] Action field takes effect at next match
// [R6] Force strobe applies action in non-PWM modes
// [R7] Only waveform select shapes the count
// [R8] Mode 0 counts up, wraps 0xff to 0
// [R9] Normal mode wrap flag set on zero
// [R10] Mode 2 clears counter at channel A compare
// [R11] Low compare write runs through 0xff first
// [R12] Mode 2 sets channel A flag at top
// [R13] Mode 2 action one toggles channel A
// [R14] Mode 2 wrap flag at max to zero
// [R15] Modes 3 and 7 single-slope; top 0xff/A
// [R16] PWM action two/three: match versus wrap
// [R17] Fast PWM clears counter tick after top
// [R18] Fast PWM sets wrap flag at top
// [R19] Compare zero spikes; compare max constant
// [R20] PWM action one toggles, buffering stays
// [R21] PWM compare buffered; otherwise written directly
// [R22] Match sets channel flag on the tick
// [R23] Force sets no flag, leaves counter alone
// [R24] Count, match and wrap step only on timer tick
// [R25] Software sets state before direction, avoids equal writes
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tcw_timer
  import tcw_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tmrTick,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pinAOut,
  output logic pinAOe,
  output logic pinBOut,
  output logic pinBOe
);
  localparam int NCH = 2;

  logic [2:0] waveSel_q;
  logic [NCH-1:0][1:0] act_q;
  logic [7:0] count_q;
  logic [NCH-1:0][7:0] cmpBuf_q;
  logic [NCH-1:0][7:0] cmp_q;
  logic [NCH-1:0] dir_q;
  logic [NCH-1:0] portOut_q;
  logic wrapFlag_q;
  logic [NCH-1:0] matchFlag_q;
  logic block_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [NCH-1:0] pinOut_q;
  logic [NCH-1:0] pinOe_q;

  tcw_wave_cls_t waveCls;
  logic pwmMode;
  logic [7:0] top;
  logic atTop;
  logic [NCH-1:0] match;
  logic [NCH-1:0] chState;
  logic wrapEv;
  logic accEdge;
  logic wrEn;
  logic wrCount;
  logic wrFlags;
  logic wrForce;
  logic [NCH-1:0] wrCmp;
  logic addrHit;
  logic [31:0] rdData;

  // Bus decode; writes land only on the edge that completes the access
  assign accEdge = psel && penable && pready_q;
  assign wrEn = accEdge && pwrite && addrHit;
  assign wrCount = wrEn && (paddr == TCW_OFF_COUNT);
  assign wrFlags = wrEn && (paddr == TCW_OFF_FLAGS);
  assign wrForce = wrEn && (paddr == TCW_OFF_FORCE);
  assign wrCmp[0] = wrEn && (paddr == TCW_OFF_CMPA);
  assign wrCmp[1] = wrEn && (paddr == TCW_OFF_CMPB);

  // Counting class comes from the waveform select alone [R7] [R15]
  always_comb begin
    case (waveSel_q)
      TCW_WAVE_NORMAL: waveCls = TCW_CLS_NORMAL;
      TCW_WAVE_CLEARMATCH: waveCls = TCW_CLS_CLEAR;
      TCW_WAVE_FAST_MAX: waveCls = TCW_CLS_FAST;
      TCW_WAVE_FAST_CMPA: waveCls = TCW_CLS_FAST;
      default: waveCls = TCW_CLS_NORMAL;
    endcase
  end

  assign pwmMode = (waveCls == TCW_CLS_FAST);
  assign top = (waveSel_q == TCW_WAVE_FAST_CMPA) ? cmp_q[0] : TCW_MAX; // [R15]
  assign atTop = (count_q == top);

  // Matches are judged on the tick and masked after a counter write [R1]
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      match[i] = tmrTick && (count_q == cmp_q[i]) && !block_q;
    end
  end

  // Wrap event: at top in fast PWM, at max otherwise [R9] [R14] [R18]
  assign wrapEv = tmrTick && (pwmMode ? atTop : (count_q == TCW_MAX));

  // Control fields; action field is not buffered, it is read live [R5]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waveSel_q <= TCW_RST_WAVE;
      act_q <= {NCH{TCW_RST_ACT}};
    end else if (wrEn && (paddr == TCW_OFF_CTRL)) begin
      waveSel_q <= pwdata[TCW_CTRL_WAVE_LSB +: 3];
      act_q <= pwdata[TCW_CTRL_ACT_LSB +: 2*NCH];
    end
  end

  // Pin configuration register: direction and general port level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_q <= TCW_RST_PIN;
      portOut_q <= TCW_RST_PIN;
    end else if (wrEn && (paddr == TCW_OFF_PINCFG)) begin
      dir_q <= pwdata[TCW_PIN_DIR_LSB +: NCH];
      portOut_q <= pwdata[TCW_PIN_PORT_LSB +: NCH];
    end
  end

  // Counter; software write outranks every clear or count [R24]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= TCW_RST_COUNT;
    end else if (wrCount) begin
      count_q <= pwdata[7:0];
    end else if (tmrTick) begin
      case (waveCls)
        TCW_CLS_FAST: count_q <= atTop ? TCW_BOTTOM : count_q + 8'h01; // [R17]
        TCW_CLS_CLEAR: count_q <= match[0] ? TCW_BOTTOM : count_q + 8'h01; // [R10] [R11]
        default: count_q <= count_q + 8'h01; // Plain wrap through 0xff [R8]
      endcase
    end
  end

  // Block armed by a counter write, consumed by the next tick [R1]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      block_q <= 1'b0;
    end else if (wrCount) begin
      block_q <= 1'b1;
    end else if (tmrTick) begin
      block_q <= 1'b0;
    end
  end

  // Compare values: direct in non-PWM, reloaded at top in PWM [R21] [R20]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmpBuf_q <= {NCH{TCW_RST_CMP}};
      cmp_q <= {NCH{TCW_RST_CMP}};
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wrCmp[i]) begin
          cmpBuf_q[i] <= pwdata[7:0];
        end
        if (wrCmp[i] && !pwmMode) begin
          cmp_q[i] <= pwdata[7:0];
        end else if (pwmMode && tmrTick && atTop) begin
          cmp_q[i] <= cmpBuf_q[i];
        end
      end
    end
  end

  // Sticky flags; write one clears, but a same-cycle set wins [R9] [R12] [R22]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrapFlag_q <= 1'b0;
      matchFlag_q <= '0;
    end else begin
      wrapFlag_q <= wrapEv || (wrapFlag_q && !(wrFlags && pwdata[TCW_FLAG_WRAP]));
      for (int i = 0; i < NCH; i++) begin
        matchFlag_q[i] <= match[i] || (matchFlag_q[i] && !(wrFlags && pwdata[TCW_FLAG_MATCH_LSB + i]));
      end
    end
  end

  // One channel instance per compare unit
  genvar g;
  for (g = 0; g < NCH; g++) begin : gCh
    tcw_chan_if chIf();
    assign chIf.tick = tmrTick;
    assign chIf.match = match[g];
    assign chIf.wrapEv = wrapEv;
    assign chIf.forceEv = wrForce && pwdata[g]; // Force never touches flags or counter [R23]
    assign chIf.pwmMode = pwmMode;
    assign chIf.action = act_q[g];
    assign chState[g] = chIf.state;
    tcw_channel uChan (
      .clk(clk),
      .sys_rst(sys_rst),
      .ch(chIf.ch)
    );
  end

  // Pin override; registered so outputs come straight from flops [R3]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut_q <= '0;
      pinOe_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        pinOut_q[i] <= (act_q[i] != TCW_ACT_NONE) ? chState[i] : portOut_q[i];
        pinOe_q[i] <= dir_q[i];
      end
    end
  end

  // Read mux; buffered compare shows what software last wrote
  always_comb begin
    rdData = 32'h00000000;
    addrHit = 1'b1;
    case (paddr)
      TCW_OFF_CTRL: rdData = {24'h000000, act_q, 1'b0, waveSel_q};
      TCW_OFF_COUNT: rdData = {24'h000000, count_q};
      TCW_OFF_CMPA: rdData = {24'h000000, cmpBuf_q[0]};
      TCW_OFF_CMPB: rdData = {24'h000000, cmpBuf_q[1]};
      TCW_OFF_PINCFG: rdData = {28'h0000000, portOut_q, dir_q};
      TCW_OFF_FLAGS: rdData = {29'h00000000, matchFlag_q, wrapFlag_q};
      TCW_OFF_FORCE: rdData = 32'h00000000;
      TCW_OFF_STATE: rdData = {30'h00000000, chState};
      default: addrHit = 1'b0;
    endcase
  end

  // APB answer one cycle into the access phase; unmapped gives pslverr
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !addrHit;
      prdata_q <= (psel && penable && !pready_q && !pwrite) ? rdData : 32'h00000000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pinAOut = pinOut_q[0];
  assign pinAOe = pinOe_q[0];
  assign pinBOut = pinOut_q[1];
  assign pinBOe = pinOe_q[1];

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_access;
    psel && penable && !pready_q;
  endsequence
  sequence s_answer;
    pready_q ##1 !pready_q;
  endsequence
  property p_apbAnswer;
    s_access |=> s_answer;
  endproperty
  a_apbAnswer: assert property (p_apbAnswer) else $error("APB answer not one cycle");

  property p_blockMatch;
    block_q && tmrTick && !wrFlags |=> matchFlag_q == $past(matchFlag_q);
  endproperty
  a_blockMatch: assert property (p_blockMatch) else $error("match seen after counter write"); // [R1]

  property p_normalWrap;
    (waveCls == TCW_CLS_NORMAL) && tmrTick && !wrCount && (count_q == TCW_MAX) |=> (count_q == 8'h00) && wrapFlag_q;
  endproperty
  a_normalWrap: assert property (p_normalWrap) else $error("normal mode wrap wrong"); // [R8] [R9]

  property p_clearMatch;
    (waveCls == TCW_CLS_CLEAR) && tmrTick && !wrCount && !block_q && (count_q == cmp_q[0])
      |=> (count_q == 8'h00) && matchFlag_q[0];
  endproperty
  a_clearMatch: assert property (p_clearMatch) else $error("clear on match failed"); // [R10] [R12]

  property p_fastTop;
    pwmMode && tmrTick && !wrCount && atTop |=> (count_q == 8'h00) && wrapFlag_q;
  endproperty
  a_fastTop: assert property (p_fastTop) else $error("fast PWM top handling wrong"); // [R17] [R18]

  property p_directCmp;
    wrCmp[0] && !pwmMode |=> cmp_q[0] == $past(pwdata[7:0]);
  endproperty
  a_directCmp: assert property (p_directCmp) else $error("direct compare write lost"); // [R21]

  property p_bufferedCmp;
    pwmMode && !(tmrTick && atTop) |=> $stable(cmp_q);
  endproperty
  a_bufferedCmp: assert property (p_bufferedCmp) else $error("active compare moved off top"); // [R21]

  property p_holdNoTick;
    !tmrTick && !wrCount |=> $stable(count_q);
  endproperty
  a_holdNoTick: assert property (p_holdNoTick) else $error("counter moved without tick"); // [R24]

  property p_pinOverride;
    (act_q[0] != TCW_ACT_NONE) |=> (pinOut_q[0] == $past(chState[0])) && (pinOe_q[0] == $past(dir_q[0]));
  endproperty
  a_pinOverride: assert property (p_pinOverride) else $error("pin A override wrong"); // [R3]

  property p_setWins;
    wrapEv && wrFlags && pwdata[TCW_FLAG_WRAP] |=> wrapFlag_q;
  endproperty
  a_setWins: assert property (p_setWins) else $error("wrap flag clear beat set"); // [R14]

  property p_forceQuiet;
    wrForce && !tmrTick |=> $stable(matchFlag_q) && $stable(count_q);
  endproperty
  a_forceQuiet: assert property (p_forceQuiet) else $error("force touched flags or counter"); // [R23]

  property p_pinEnable;
    1'b1 |=> pinOe_q == $past(dir_q);
  endproperty
  a_pinEnable: assert property (p_pinEnable) else $error("pin enable not from direction bit"); // [R3]

  property p_pinPortB;
    (act_q[1] == TCW_ACT_NONE) |=> pinOut_q[1] == $past(portOut_q[1]);
  endproperty
  a_pinPortB: assert property (p_pinPortB) else $error("pin B port level not passed"); // [R3]

  // Compare below the count is missed, so max still wraps with the flag
  property p_clearWrap;
    (waveCls == TCW_CLS_CLEAR) && tmrTick && !wrCount && (count_q == TCW_MAX) && (cmp_q[0] != TCW_MAX)
      |=> (count_q == 8'h00) && wrapFlag_q;
  endproperty
  a_clearWrap: assert property (p_clearWrap) else $error("clear mode wrap at max wrong"); // [R11] [R14]
endmodule : tcw_timer
`default_nettype wire

// *** core/tcw_pkg.sv ***
// Shared constants and types for the timer compare and waveform unit
package tcw_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] TCW_OFF_CTRL = 8'h00;
  localparam logic [7:0] TCW_OFF_COUNT = 8'h04;
  localparam logic [7:0] TCW_OFF_CMPA = 8'h08;
  localparam logic [7:0] TCW_OFF_CMPB = 8'h0c;
  localparam logic [7:0] TCW_OFF_PINCFG = 8'h10;
  localparam logic [7:0] TCW_OFF_FLAGS = 8'h14;
  localparam logic [7:0] TCW_OFF_FORCE = 8'h18;
  localparam logic [7:0] TCW_OFF_STATE = 8'h1c;

  // Field positions
  localparam int TCW_CTRL_WAVE_LSB = 0;
  localparam int TCW_CTRL_ACT_LSB = 4;
  localparam int TCW_PIN_DIR_LSB = 0;
  localparam int TCW_PIN_PORT_LSB = 2;
  localparam int TCW_FLAG_WRAP = 0;
  localparam int TCW_FLAG_MATCH_LSB = 1;

  // Values after reset
  localparam logic [2:0] TCW_RST_WAVE = 3'h0;
  localparam logic [1:0] TCW_RST_ACT = 2'h0;
  localparam logic [7:0] TCW_RST_COUNT = 8'h00;
  localparam logic [7:0] TCW_RST_CMP = 8'h00;
  localparam logic [1:0] TCW_RST_PIN = 2'h0;

  // Count extremes
  localparam logic [7:0] TCW_MAX = 8'hff;
  localparam logic [7:0] TCW_BOTTOM = 8'h00;

  // Waveform select codes
  localparam logic [2:0] TCW_WAVE_NORMAL = 3'h0;
  localparam logic [2:0] TCW_WAVE_CLEARMATCH = 3'h2;
  localparam logic [2:0] TCW_WAVE_FAST_MAX = 3'h3;
  localparam logic [2:0] TCW_WAVE_FAST_CMPA = 3'h7;

  // Output action field codes
  localparam logic [1:0] TCW_ACT_NONE = 2'h0;
  localparam logic [1:0] TCW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TCW_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TCW_ACT_SET = 2'h3;

  // Counting behaviour class decoded from the waveform select
  typedef enum logic [1:0] {TCW_CLS_NORMAL, TCW_CLS_CLEAR, TCW_CLS_FAST} tcw_wave_cls_t;
endpackage : tcw_pkg

// *** core/tcw_chan_if.sv ***
// Bundle between the counter core and one compare channel
`timescale 1ns/1ps
`default_nettype none
interface tcw_chan_if;
  logic tick;
  logic match;
  logic wrapEv;
  logic forceEv;
  logic pwmMode;
  logic [1:0] action;
  logic state;
  modport ctl(output tick, output match, output wrapEv, output forceEv, output pwmMode, output action, input state);
  modport ch(input tick, input match, input wrapEv, input forceEv, input pwmMode, input action, output state);
endinterface : tcw_chan_if
`default_nettype wire

// *** core/tcw_channel.sv ***
// One compare channel: the internal output state register and its actions
`timescale 1ns/1ps
`default_nettype none
module tcw_channel
  import tcw_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  tcw_chan_if.ch ch
);
  logic state_q;

  // Applies one action code to the present state
  function automatic logic actOut(input logic [1:0] act, input logic cur);
    logic res;
    res = cur;
    case (act)
      TCW_ACT_TOGGLE: res = ~cur;
      TCW_ACT_CLEAR: res = 1'b0;
      TCW_ACT_SET: res = 1'b1;
      default: res = cur;
    endcase
    return res;
  endfunction : actOut

  // State changes only on force, match or wrap; mode switches leave it alone [R2]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= 1'b0;
    end else if (ch.forceEv && !ch.pwmMode) begin
      state_q <= actOut(ch.action, state_q); // Force ignored in PWM modes [R6] [R23]
    end else if (ch.tick) begin
      if (ch.pwmMode && ch.wrapEv && ch.action[1]) begin
        state_q <= ~ch.action[0]; // Wrap wins over match, so max compare is constant [R16] [R19]
      end else if (ch.match) begin
        state_q <= actOut(ch.action, state_q); // Action zero holds; field read live [R4] [R5] [R13] [R20]
      end
    end
  end

  assign ch.state = state_q;

  property p_noneHolds;
    @(posedge clk) disable iff (sys_rst)
    (ch.action == TCW_ACT_NONE) && !(ch.forceEv && !ch.pwmMode) |=> $stable(state_q);
  endproperty
  a_noneHolds: assert property (p_noneHolds) else $error("state moved with action none"); // [R4]

  property p_toggle;
    @(posedge clk) disable iff (sys_rst)
    ch.tick && ch.match && (ch.action == TCW_ACT_TOGGLE) && !ch.forceEv |=> state_q != $past(state_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle on match missing"); // [R13]

  property p_forcePwm;
    @(posedge clk) disable iff (sys_rst)
    ch.forceEv && ch.pwmMode && !ch.tick |=> $stable(state_q);
  endproperty
  a_forcePwm: assert property (p_forcePwm) else $error("force acted in PWM mode"); // [R6]

  property p_pwmWrap;
    @(posedge clk) disable iff (sys_rst)
    ch.pwmMode && ch.tick && ch.wrapEv && (ch.action == TCW_ACT_CLEAR) && !ch.forceEv |=> state_q;
  endproperty
  a_pwmWrap: assert property (p_pwmWrap) else $error("non-inverted output not set at wrap"); // [R16]
endmodule : tcw_channel
`default_nettype wire

// *** tb/tcw_pin_load.sv ***
// External load on the two compare pins, weak pull-up when undriven
`timescale 1ns/1ps
`default_nettype none
module tcw_pin_load (
  input wire logic pinAOut,
  input wire logic pinAOe,
  input wire logic pinBOut,
  input wire logic pinBOe,
  output logic padA,
  output logic padB
);
  // Pull-up shows only while the pin is released, so a stale level never lingers
  assign padA = pinAOe ? pinAOut : 1'b1;
  assign padB = pinBOe ? pinBOut : 1'b1;
endmodule : tcw_pin_load
`default_nettype wire

// *** tb/tcw_timer_tb.sv ***
// Self-checking bench for the timer compare and waveform unit
`timescale 1ns/1ps
`default_nettype none
module tcw_timer_tb
  import tcw_pkg::*;
;
  logic clk, sys_rst, tmrTick, psel, penable, pwrite, pready, pslverr;
  logic pinAOut, pinAOe, pinBOut, pinBOe, padA, padB, lastErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, lastData;
  int n_fail = 0;
  int compares = 0;

  tcw_timer i_dut (.clk(clk), .sys_rst(sys_rst), .tmrTick(tmrTick), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinAOut(pinAOut), .pinAOe(pinAOe), .pinBOut(pinBOut), .pinBOe(pinBOe));
  tcw_pin_load i_load (.pinAOut(pinAOut), .pinAOe(pinAOe), .pinBOut(pinBOut), .pinBOe(pinBOe),
    .padA(padA), .padB(padB));

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    lastData = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (k >= 16) begin
      n_fail++;
      test_done();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, lastData);
  endtask : rc

  // Timer enable held for n edges, then dropped so the count rests
  task automatic step(input int n);
    tmrTick <= 1'b1;
    repeat (n) @(posedge clk);
    tmrTick <= 1'b0;
    @(posedge clk);
  endtask : step

  function automatic logic [31:0] ctl(input logic [2:0] w, input logic [1:0] act);
    return {26'h0, act, 1'b0, w};
  endfunction : ctl

  task automatic t_reset();
    rc(TCW_OFF_CTRL, 32'h0, "ctrl");
    rc(TCW_OFF_COUNT, 32'h0, "count");
    rc(TCW_OFF_FLAGS, 32'h0, "flags");
    chk("pin a enable", 32'h0, {31'h0, pinAOe});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, lastErr});
    chk("unmapped data", 32'h0, lastData);
    wr(TCW_OFF_CMPB, 32'h99);
    $display("test reset done");
  endtask : t_reset

  task automatic t_normal();
    wr(TCW_OFF_COUNT, 32'hfe);
    repeat (5) @(posedge clk);
    rc(TCW_OFF_COUNT, 32'hfe, "count without tick");
    step(2);
    rc(TCW_OFF_COUNT, 32'h0, "count rollover");
    rc(TCW_OFF_FLAGS, 32'h1, "wrap flag");
    wr(TCW_OFF_FLAGS, 32'h7);
    $display("test normal done");
  endtask : t_normal

  task automatic t_block();
    wr(TCW_OFF_CMPA, 32'h10);
    wr(TCW_OFF_COUNT, 32'h10);
    step(1);
    rc(TCW_OFF_FLAGS, 32'h0, "blocked match");
    wr(TCW_OFF_COUNT, 32'h0e);
    step(2);
    rc(TCW_OFF_FLAGS, 32'h0, "flag too early");
    step(1);
    rc(TCW_OFF_FLAGS, 32'h2, "match flag");
    rc(TCW_OFF_STATE, 32'h0, "state with action zero");
    wr(TCW_OFF_FLAGS, 32'h7);
    $display("test block done");
  endtask : t_block

  task automatic t_ctc();
    wr(TCW_OFF_CTRL, ctl(TCW_WAVE_CLEARMATCH, TCW_ACT_TOGGLE));
    wr(TCW_OFF_CMPA, 32'h3);
    wr(TCW_OFF_COUNT, 32'h0);
    step(4);
    rc(TCW_OFF_COUNT, 32'h0, "cleared at compare");
    rc(TCW_OFF_FLAGS, 32'h2, "top flag");
    rc(TCW_OFF_STATE, 32'h1, "toggled state");
    wr(TCW_OFF_FLAGS, 32'h7);
    wr(TCW_OFF_COUNT, 32'hfd);
    wr(TCW_OFF_CMPA, 32'h2);
    step(3);
    rc(TCW_OFF_COUNT, 32'h0, "runs past low compare");
    rc(TCW_OFF_FLAGS, 32'h1, "wrap flag");
    wr(TCW_OFF_PINCFG, 32'h1);
    @(posedge clk);
    chk("pin a enable", 32'h1, {31'h0, pinAOe});
    chk("pad from state", 32'h1, {31'h0, padA});
    wr(TCW_OFF_CTRL, ctl(TCW_WAVE_NORMAL, TCW_ACT_TOGGLE));
    rc(TCW_OFF_STATE, 32'h1, "state over mode switch");
    wr(TCW_OFF_CTRL, ctl(TCW_WAVE_NORMAL, TCW_ACT_NONE));
    @(posedge clk);
    chk("pad from port bit", 32'h0, {31'h0, padA});
    wr(TCW_OFF_PINCFG, 32'h0);
    @(posedge clk);
    chk("pad released", 32'h1, {31'h0, padA});
    wr(TCW_OFF_FLAGS, 32'h7);
    $display("test clear on match done");
  endtask : t_ctc

  task automatic t_force();
    wr(TCW_OFF_CTRL, ctl(TCW_WAVE_NORMAL, TCW_ACT_CLEAR));
    wr(TCW_OFF_COUNT, 32'h40);
    wr(TCW_OFF_FORCE, 32'h1);
    rc(TCW_OFF_STATE, 32'h0, "forced clear");
    rc(TCW_OFF_COUNT, 32'h40, "count after force");
    rc(TCW_OFF_FLAGS, 32'h0, "flag after force");
    wr(TCW_OFF_CTRL, ctl(TCW_WAVE_NORMAL, TCW_ACT_SET));
    wr(TCW_OFF_FORCE, 32'h1);
    rc(TCW_OFF_STATE, 32'h1, "forced set");
    wr(TCW_OFF_CMPA, 32'h42);
    wr(TCW_OFF_CTRL, ctl(TCW_WAVE_NORMAL, TCW_ACT_CLEAR));
    step(3);
    rc(TCW_OFF_STATE, 32'h0, "new action at match");
    wr(TCW_OFF_CTRL, ctl(TCW_WAVE_NORMAL, TCW_ACT_TOGGLE));
    wr(TCW_OFF_FORCE, 32'h1);
    rc(TCW_OFF_STATE, 32'h1, "forced toggle");
    wr(TCW_OFF_FORCE, 32'h1);
    wr(TCW_OFF_CTRL, ctl(TCW_WAVE_FAST_MAX, TCW_ACT_TOGGLE));
    wr(TCW_OFF_FORCE, 32'h1);
    rc(TCW_OFF_STATE, 32'h0, "force ignored in pwm");
    wr(TCW_OFF_FLAGS, 32'h7);
    $display("test force done");
  endtask : t_force

  // Channel B: force, pin override and match with its own compare
  task automatic t_chanb();
    wr(TCW_OFF_CTRL, 32'hc0);
    wr(TCW_OFF_FORCE, 32'h2);
    rc(TCW_OFF_STATE, 32'h2, "forced set b");
    wr(TCW_OFF_PINCFG, 32'h2);
    @(posedge clk);
    chk("pin b enable", 32'h1, {31'h0, pinBOe});
    chk("pad b from state", 32'h1, {31'h0, padB});
    wr(TCW_OFF_CTRL, 32'h80);
    wr(TCW_OFF_COUNT, 32'h98);
    step(2);
    rc(TCW_OFF_FLAGS, 32'h4, "match flag b");
    rc(TCW_OFF_STATE, 32'h0, "cleared b at match");
    chk("pad b cleared", 32'h0, {31'h0, padB});
    wr(TCW_OFF_PINCFG, 32'h0);
    wr(TCW_OFF_CTRL, 32'h0);
    wr(TCW_OFF_FLAGS, 32'h7);
    $display("test channel b done");
  endtask : t_chanb

  task automatic t_pwm();
    wr(TCW_OFF_CTRL, ctl(TCW_WAVE_FAST_MAX, TCW_ACT_CLEAR));
    wr(TCW_OFF_COUNT, 32'hfe);
    step(2);
    rc(TCW_OFF_COUNT, 32'h0, "restart after top");
    rc(TCW_OFF_FLAGS, 32'h1, "wrap flag at top");
    rc(TCW_OFF_STATE, 32'h1, "set at wrap");
    wr(TCW_OFF_CMPA, 32'h5);
    rc(TCW_OFF_CMPA, 32'h5, "compare buffer");
    step(7);
    rc(TCW_OFF_STATE, 32'h1, "buffered compare unused");
    wr(TCW_OFF_COUNT, 32'hfe);
    step(8);
    rc(TCW_OFF_STATE, 32'h0, "cleared at match");
    rc(TCW_OFF_FLAGS, 32'h3, "flags");
    wr(TCW_OFF_CTRL, ctl(TCW_WAVE_FAST_CMPA, TCW_ACT_SET));
    wr(TCW_OFF_COUNT, 32'h3);
    step(3);
    rc(TCW_OFF_COUNT, 32'h0, "top from compare a");
    rc(TCW_OFF_STATE, 32'h0, "compare at top");
    wr(TCW_OFF_CTRL, ctl(TCW_WAVE_FAST_CMPA, TCW_ACT_TOGGLE));
    step(6);
    rc(TCW_OFF_STATE, 32'h1, "toggle at match");
    step(6);
    rc(TCW_OFF_STATE, 32'h0, "toggle next period");
    $display("test fast pwm done");
  endtask : t_pwm

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    tmrTick = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_normal();
    t_block();
    t_ctc();
    t_force();
    t_chanb();
    t_pwm();
    test_done();
  end
endmodule : tcw_timer_tb
`default_nettype wire
